// ### aux_nibble.sv
// Quasi-bidirectional four bit port with weak internal pull-ups.
// Assumes the pad resolves a weak high against an external low.
module aux_nibble #(parameter int unsigned WIDTH = ext_bus_pkg::AUX_WIDTH)
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Core side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data,
  // Pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pull_up_en
  );
  logic [WIDTH-1:0] latch;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      latch <= '1;
    else if (wr_en)
      latch <= wr_data;
  end
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // A one only pulls up, so the bit can be read as input
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pin_out[i] <= 1'b1;
          pin_oe[i] <= 1'b0;
          pull_up_en[i] <= 1'b1;
          rd_data[i] <= 1'b1;
        end
        else
        begin
          pin_out[i] <= latch[i];
          pin_oe[i] <= ~latch[i];
          pull_up_en[i] <= latch[i];
          rd_data[i] <= pin_in[i];
        end
      end
    end
  endgenerate
endmodule : aux_nibble

// ### cycle_phase_gen.sv
// Machine cycle phase counter, twelve or six clocks per cycle.
// Assumes phase counts in twelfths of a machine cycle in both modes.
module cycle_phase_gen
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Mode
  input wire logic six_clock_mode,
  // Phase
  output logic [ext_bus_pkg::PHASE_W-1:0] phase,
  output logic cycle_end
  );
  logic [ext_bus_pkg::PHASE_W-1:0] last_phase;
  logic [ext_bus_pkg::PHASE_W-1:0] step;
  logic [ext_bus_pkg::PHASE_W-1:0] next_phase;
  // Fast mode runs two phase steps per clock, halving the cycle
  assign last_phase = six_clock_mode ? 4'(ext_bus_pkg::CLK_PER_CYCLE_STD - 2)
                                     : 4'(ext_bus_pkg::CLK_PER_CYCLE_STD - 1);
  assign step = six_clock_mode ? 4'h2 : 4'h1;
  assign next_phase = (phase >= last_phase) ? 4'h0 : 4'(phase + step);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= 4'h0;
      cycle_end <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      cycle_end <= (next_phase >= last_phase);
    end
  end
endmodule : cycle_phase_gen

// ### ext_bus_monitor.sv
// Checker of strobe timing and reset entry at the block's ports.
// Assumes the bind below attaches it to every strobe block.
module ext_bus_monitor
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic reset_pin,
  input wire logic six_clock_mode,
  input wire logic latch_strobe_off,
  input wire logic external_fetch,
  input wire logic program_store_strobe_n,
  input wire logic program_store_strobe_oe,
  input wire logic address_latch_strobe,
  input wire logic normal_mode,
  input wire logic device_reset
  );
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [5:0] hold;
  // Saturates so a long reset never wraps to zero
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      hold <= 6'h00;
    else if (!reset_pin)
      hold <= 6'h00;
    else if (hold != 6'h3f)
      hold <= hold + 6'h01;
  a_internal_idle_high: assert property (
    !external_fetch [*2] |-> program_store_strobe_n) else $error("store strobe while internal");
  a_store_one_clock: assert property (
    $fell(program_store_strobe_n) |=> program_store_strobe_n) else $error("store strobe long");
  a_latch_one_clock: assert property (
    $rose(address_latch_strobe) |=> !address_latch_strobe) else $error("latch pulse long");
  a_latch_then_store: assert property (
    $rose(address_latch_strobe) && !six_clock_mode |->
    ##2 (!program_store_strobe_n || !external_fetch)) else $error("store strobe late");
  a_latch_off_quiet: assert property (
    latch_strobe_off [*2] |-> !address_latch_strobe) else $error("latch while disabled");
  a_latch_spacing: assert property (
    $rose(address_latch_strobe) |=> (!address_latch_strobe || six_clock_mode) [*5])
    else $error("latch pulses too close");
  a_idle_outside_normal: assert property (
    !normal_mode [*2] |-> program_store_strobe_n && !program_store_strobe_oe)
    else $error("strobe driven outside normal mode");
  a_reset_after_hold: assert property (
    hold == 6'h1a |-> device_reset) else $error("reset not taken");
endmodule : ext_bus_monitor

bind ext_bus_strobes ext_bus_monitor mon (.core_clk, .rst_n, .reset_pin, .six_clock_mode,
  .latch_strobe_off, .external_fetch, .program_store_strobe_n, .program_store_strobe_oe,
  .address_latch_strobe, .normal_mode, .device_reset);

// ### ext_bus_pkg.sv
// Constants shared by the external bus strobe and mode entry block.
// Assumes a single core clock; crystal rate equals the core clock rate.
package ext_bus_pkg;
  localparam int unsigned CLK_PER_CYCLE_STD = 12;
  localparam int unsigned CLK_PER_CYCLE_FAST = 6;
  localparam int unsigned RESET_HOLD_CYCLES = 2;
  localparam int unsigned HOST_ENTRY_CYCLES = 20;
  localparam int unsigned LOCK_LEVEL_NO_EXT = 4;
  localparam int unsigned AUX_WIDTH = 4;
  localparam int unsigned PHASE_W = 4;
  localparam int unsigned MCYC_W = 6;
  localparam logic [PHASE_W-1:0] PH_LATCH_A = 4'h0;
  localparam logic [PHASE_W-1:0] PH_STORE_A = 4'h2;
  localparam logic [PHASE_W-1:0] PH_LATCH_B = 4'h6;
  localparam logic [PHASE_W-1:0] PH_STORE_B = 4'h8;
  localparam logic [PHASE_W-1:0] PH_DATA = 4'h8;
  localparam logic [2:0] LOCK_LEVEL_W4 = 3'h4;
  typedef enum logic [1:0] {MODE_RESET, MODE_NORMAL, MODE_HOST} run_mode_t;
endpackage : ext_bus_pkg

// ### ext_bus_strobes.sv
// External bus strobes, address latch and mode entry after reset.
// Assumes pins are synchronous to core_clk and crystal equals core_clk.
// Operation
// - Internal execution keeps program store strobe high
// - External fetch strobes program store twice per cycle
// - Data access cycle skips one program strobe
// - Host mode: strobe falls, reset held over 20 cycles
// - Reset after two machine cycles high
// - Otherwise normal mode after reset
// - Fetch enable low selects external code
// - Lock level four forces internal execution
// - Latch strobe pulses each external access
// - Latch strobe at one sixth crystal
// - Data access drops one latch pulse
// - Latch off bit stops latch pulses
// - Latch pin takes burn pulse in programming
// - Written one pulls aux bit high
// - Port 3 bits carry data strobes
// - Six clock mode gives one third rate
module ext_bus_strobes
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Device pins
  input wire logic reset_pin,
  input wire logic external_fetch_enable_n,
  input wire logic store_strobe_in,
  output logic program_store_strobe_n,
  output logic program_store_strobe_oe,
  input wire logic latch_pin_in,
  output logic address_latch_strobe,
  output logic address_latch_oe,
  output logic [7:0] port3_out,
  // Core control
  input wire logic six_clock_mode,
  input wire logic latch_strobe_off,
  input wire logic [2:0] lock_level,
  input wire logic flash_programming,
  input wire logic data_access,
  input wire logic data_write,
  input wire logic [7:0] port3_latch,
  // Status to core
  output logic external_fetch,
  output logic device_reset,
  output logic host_mode,
  output logic normal_mode,
  output logic burn_pulse_in_n,
  // Aux port
  input wire logic aux_wr_en,
  input wire logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_wr_data,
  output logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_rd_data,
  input wire logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_nibble_port_in,
  output logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_nibble_port_out,
  output logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_nibble_port_oe,
  output logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_nibble_port_pull_up
  );
  localparam int unsigned WR_BIT = 6;
  localparam int unsigned RD_BIT = 7;

  logic [ext_bus_pkg::PHASE_W-1:0] phase;
  logic cycle_end;
  ext_bus_pkg::run_mode_t mode;
  ext_bus_pkg::run_mode_t next_mode;
  logic [ext_bus_pkg::MCYC_W-1:0] reset_cycles;
  logic [ext_bus_pkg::MCYC_W-1:0] next_reset_cycles;
  logic store_strobe_prev;
  logic host_edge_seen;
  logic data_cycle;

  cycle_phase_gen u_phase
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .six_clock_mode(six_clock_mode),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  aux_nibble #(.WIDTH(ext_bus_pkg::AUX_WIDTH)) u_aux
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(aux_wr_en),
    .wr_data(aux_wr_data),
    .rd_data(aux_rd_data),
    .pin_in(aux_nibble_port_in),
    .pin_out(aux_nibble_port_out),
    .pin_oe(aux_nibble_port_oe),
    .pull_up_en(aux_nibble_port_pull_up)
  );

  // Fetch source select
  wire lock_blocks_ext = (lock_level == ext_bus_pkg::LOCK_LEVEL_W4);
  wire fetch_ext = !external_fetch_enable_n && !lock_blocks_ext;

  // Reset counting in machine cycles; pin held high means reset asserted
  wire reset_held = reset_pin;
  wire reset_long = reset_cycles >= 6'(ext_bus_pkg::RESET_HOLD_CYCLES);
  wire host_window = reset_cycles > 6'(ext_bus_pkg::HOST_ENTRY_CYCLES);
  wire store_fall = store_strobe_prev && !store_strobe_in;
  assign next_reset_cycles = !reset_held ? 6'h0 :
                             (cycle_end && !(&reset_cycles)) ? 6'(reset_cycles + 1)
                                                             : reset_cycles;

  // Mode decision at reset release
  always_comb
  begin
    next_mode = mode;
    case (mode)
      ext_bus_pkg::MODE_RESET:
        if (!reset_held)
          next_mode = host_edge_seen ? ext_bus_pkg::MODE_HOST
                                     : ext_bus_pkg::MODE_NORMAL;
      ext_bus_pkg::MODE_NORMAL,
      ext_bus_pkg::MODE_HOST:
        if (reset_long)
          next_mode = ext_bus_pkg::MODE_RESET;
      default:
        next_mode = ext_bus_pkg::MODE_RESET;
    endcase
  end

  // Strobe timing; data cycles replace the second fetch half
  wire in_normal = (mode == ext_bus_pkg::MODE_NORMAL);
  wire fetch_phase = (phase == ext_bus_pkg::PH_STORE_A) ||
                     (phase == ext_bus_pkg::PH_STORE_B && !data_cycle);
  wire next_store_n = !(in_normal && fetch_ext && fetch_phase);
  wire latch_phase = (phase == ext_bus_pkg::PH_LATCH_A) ||
                     (phase == ext_bus_pkg::PH_LATCH_B && !data_cycle);
  // Pin turns input while programming so the burn pulse can drive it
  wire latch_is_input = flash_programming || (mode == ext_bus_pkg::MODE_HOST);
  wire next_latch = in_normal && !latch_strobe_off && !latch_is_input && latch_phase;
  wire data_strobe = in_normal && data_cycle && (phase >= ext_bus_pkg::PH_DATA);
  wire next_wr_n = !(data_strobe && data_write);
  wire next_rd_n = !(data_strobe && !data_write);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= ext_bus_pkg::MODE_RESET;
      reset_cycles <= 6'h0;
      store_strobe_prev <= 1'b1;
      host_edge_seen <= 1'b0;
      data_cycle <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      reset_cycles <= next_reset_cycles;
      store_strobe_prev <= store_strobe_in;
      // Edge counts only once reset has stood long enough
      if (!reset_held)
        host_edge_seen <= 1'b0;
      else if (store_fall && host_window)
        host_edge_seen <= 1'b1;
      // Data access latched at the cycle boundary, steady for one cycle
      if (cycle_end)
        data_cycle <= data_access;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_store_strobe_n <= 1'b1;
      program_store_strobe_oe <= 1'b0;
      address_latch_strobe <= 1'b0;
      address_latch_oe <= 1'b0;
      port3_out <= 8'hff;
      external_fetch <= 1'b0;
      device_reset <= 1'b1;
      host_mode <= 1'b0;
      normal_mode <= 1'b0;
      burn_pulse_in_n <= 1'b1;
    end
    else
    begin
      // Strobe pin released during reset so the host can drive the edge
      program_store_strobe_n <= next_store_n;
      program_store_strobe_oe <= in_normal;
      address_latch_strobe <= next_latch;
      address_latch_oe <= in_normal && !latch_is_input;
      port3_out <= port3_latch;
      port3_out[WR_BIT] <= port3_latch[WR_BIT] & next_wr_n;
      port3_out[RD_BIT] <= port3_latch[RD_BIT] & next_rd_n;
      external_fetch <= fetch_ext;
      device_reset <= (next_mode == ext_bus_pkg::MODE_RESET);
      host_mode <= (next_mode == ext_bus_pkg::MODE_HOST);
      normal_mode <= (next_mode == ext_bus_pkg::MODE_NORMAL);
      burn_pulse_in_n <= latch_is_input ? latch_pin_in : 1'b1;
    end
  end
endmodule : ext_bus_strobes

// ### ext_bus_strobes_test.sv
// Self-checking bench for the external bus strobe block.
// Assumes the checker and the memory model are compiled before it.
module ext_bus_strobes_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst_n = 1'b0, reset_pin = 1'b0, external_fetch_enable_n = 1'b1;
  logic six_clock_mode = 1'b0, latch_strobe_off = 1'b0, flash_programming = 1'b0;
  logic data_access = 1'b0, data_write = 1'b0, aux_wr_en = 1'b0, host_low = 1'b0, clear = 1'b0;
  logic [2:0] lock_level = 3'h0;
  logic [3:0] aux_wr_data = 4'h0, aux_nibble_port_out, aux_nibble_port_oe, aux_nibble_port_pull_up;
  logic [3:0] aux_rd_data;
  logic [7:0] port3_out, n_lat, n_st, n_dat;
  logic program_store_strobe_n, program_store_strobe_oe, address_latch_strobe, address_latch_oe;
  logic external_fetch, device_reset, host_mode, normal_mode, burn_pulse_in_n;
  logic store_strobe_in, latch_pin_in;
  int n_fail = 0, checked = 0;
  ext_bus_strobes dut (.core_clk, .rst_n, .reset_pin, .external_fetch_enable_n,
    .store_strobe_in, .program_store_strobe_n, .program_store_strobe_oe, .latch_pin_in,
    .address_latch_strobe, .address_latch_oe, .port3_out, .six_clock_mode, .latch_strobe_off,
    .lock_level, .flash_programming, .data_access, .data_write, .port3_latch(8'hff),
    .external_fetch, .device_reset, .host_mode, .normal_mode, .burn_pulse_in_n, .aux_wr_en,
    .aux_wr_data, .aux_rd_data, .aux_nibble_port_in(aux_nibble_port_out | ~aux_nibble_port_oe),
    .aux_nibble_port_out, .aux_nibble_port_oe, .aux_nibble_port_pull_up);
  ext_mem_model mem (.core_clk, .clear, .host_low, .st_n(program_store_strobe_n),
    .st_oe(program_store_strobe_oe), .lat(address_latch_strobe), .lat_oe(address_latch_oe),
    .data_n(port3_out[7:6]), .store_line(store_strobe_in), .latch_line(latch_pin_in),
    .n_lat, .n_st, .n_dat);
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // Window of 120 clocks holds whole periods of every strobe pattern
  task automatic measure(input logic [5:0] cfg, input logic [7:0] e_lat, e_st, e_dat);
    {data_write, lock_level[2], six_clock_mode, latch_strobe_off, data_access,
      external_fetch_enable_n} = cfg;
    repeat (24) @(negedge core_clk);
    clear = 1'b1;
    @(negedge core_clk);
    clear = 1'b0;
    repeat (120) @(negedge core_clk);
    chk(n_lat, e_lat, "latch pulses");
    chk(n_st, e_st, "store strobes");
    chk(n_dat, e_dat, "data strobes");
  endtask : measure
  task automatic t_reset;
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({7'h00, normal_mode}, 8'h01, "normal mode");
    chk({7'h00, program_store_strobe_n}, 8'h01, "strobe idle");
    chk(port3_out, 8'hff, "data strobes idle");
    chk({7'h00, external_fetch}, 8'h00, "internal fetch");
    $display("reset test done");
  endtask : t_reset
  task automatic t_traffic;
    measure(6'h01, 8'h14, 8'h00, 8'h00);
    measure(6'h00, 8'h14, 8'h14, 8'h00);
    measure(6'h02, 8'h0a, 8'h0a, 8'h0a);
    measure(6'h22, 8'h0a, 8'h0a, 8'ha0);
    measure(6'h10, 8'h14, 8'h00, 8'h00);
    measure(6'h04, 8'h00, 8'h14, 8'h00);
    measure(6'h08, 8'h28, 8'h28, 8'h00);
    $display("traffic test done");
  endtask : t_traffic
  task automatic t_aux;
    aux_wr_data = 4'h5;
    aux_wr_en = 1'b1;
    @(negedge core_clk);
    aux_wr_en = 1'b0;
    @(negedge core_clk);
    chk({4'h0, aux_nibble_port_pull_up}, 8'h05, "pull-ups");
    chk({4'h0, aux_nibble_port_oe}, 8'h0a, "drivers");
    @(negedge core_clk);
    chk({4'h0, aux_rd_data}, 8'h05, "pin readback");
    $display("aux test done");
  endtask : t_aux
  task automatic t_host;
    reset_pin = 1'b1;
    repeat (300) @(negedge core_clk);
    chk({7'h00, device_reset}, 8'h01, "device reset");
    host_low = 1'b1;
    repeat (4) @(negedge core_clk);
    reset_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    host_low = 1'b0;
    chk({7'h00, host_mode}, 8'h01, "host mode");
    flash_programming = 1'b1;
    host_low = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({7'h00, burn_pulse_in_n}, 8'h00, "burn pulse");
    host_low = 1'b0;
    flash_programming = 1'b0;
    reset_pin = 1'b1;
    repeat (40) @(negedge core_clk);
    reset_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({6'h00, host_mode, normal_mode}, 8'h01, "plain restart");
    $display("host test done");
  endtask : t_host
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    #200000;
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end
  initial
  begin
    repeat (3) @(negedge core_clk);
    t_reset();
    t_traffic();
    t_aux();
    t_host();
    results();
  end
endmodule : ext_bus_strobes_test

// ### ext_mem_model.sv
// External memory and programmer: counts strobes, drives shared pins.
// Assumes both shared pins rest high on pull-ups when undriven.
module ext_mem_model
  (
  // Clock and control
  input wire logic core_clk,
  input wire logic clear,
  input wire logic host_low,
  // Device side
  input wire logic st_n,
  input wire logic st_oe,
  input wire logic lat,
  input wire logic lat_oe,
  input wire logic [1:0] data_n,
  // Pins and counts
  output logic store_line,
  output logic latch_line,
  output logic [7:0] n_lat,
  output logic [7:0] n_st,
  output logic [7:0] n_dat
  );
  timeunit 1ns;
  timeprecision 1ns;
  logic lat_q, st_q;
  logic [1:0] dat_q;
  logic [1:0] dat_fall;
  // Read and write kept apart so a swapped strobe cannot pass
  assign dat_fall = dat_q & ~data_n;
  assign store_line = st_oe ? st_n : !host_low; // Host forces the falling edge
  assign latch_line = lat_oe ? lat : !host_low; // Programming pulse
  // Edge counts only, so pulse width is left to the checker
  always_ff @(posedge core_clk)
  begin
    lat_q <= lat;
    st_q <= st_n;
    dat_q <= data_n;
    n_lat <= clear ? 8'h00 : n_lat + 8'(lat && !lat_q);
    n_st <= clear ? 8'h00 : n_st + 8'(!st_n && st_q);
    // Write falls count in the high nibble, read falls in the low one
    n_dat <= clear ? 8'h00 : n_dat + {3'h0, dat_fall[0], 3'h0, dat_fall[1]};
  end
endmodule : ext_mem_model
